// ---- hdl/efa_fas_search.sv ----
`timescale 1ns/1ps
`include "efa_regs.svh"

module efa_fas_search
  import efa_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        line_clk,
  input  wire logic        line_data,
  input  wire logic        restart,
  input  wire efa_cfg_t    cfg,
  output efa_status_t      status
);

  efa_regs_t  r_q;
  efa_regs_t  r_d;
  logic       bit_stb;
  logic       rx_bit;
  logic [6:0] shift_n;
  logic [8:0] cnt_n;

  function automatic logic fas_match(input logic [6:0] w);
    fas_match = (w == `EFA_FAS_PATTERN);
  endfunction

  // edge taken between second and third stage, never off the first
  assign bit_stb = r_q.clk_s2 & ~r_q.clk_s3;
  assign rx_bit  = r_q.dat_s2;
  assign shift_n = {r_q.shift[5:0], rx_bit};
  assign cnt_n   = r_q.cnt + 9'h001;

  always_comb begin
    r_d                 = r_q;
    r_d.clk_s1          = line_clk;
    r_d.clk_s2          = r_q.clk_s1;
    r_d.clk_s3          = r_q.clk_s2;
    r_d.dat_s1          = line_data;
    r_d.dat_s2          = r_q.dat_s1;
    r_d.sts.frame_pulse = 1'b0;
    // config frozen outside search so a running check is not disturbed
    if (r_q.st == EFA_ST_SEARCH) begin
      r_d.alg  = cfg.alignment_algorithm_select;
      r_d.xchk = cfg.extra_frame_check_en;
    end
    if (bit_stb) begin
      r_d.shift = shift_n;
      r_d.cnt   = cnt_n;
      case (r_q.st)
        EFA_ST_SEARCH: begin
          if (fas_match(shift_n)) begin
            r_d.st  = EFA_ST_NFAS;
            r_d.cnt = `EFA_FAS_POS;
          end
        end
        EFA_ST_NFAS: begin
          if (cnt_n == `EFA_NFAS_POS) begin
            if (rx_bit) begin
              r_d.st = EFA_ST_FAS3;
            end else if (r_q.alg) begin
              r_d.st = EFA_ST_HOLD;
            end else begin
              r_d.st = EFA_ST_SEARCH;
            end
          end
        end
        EFA_ST_FAS3: begin
          if (cnt_n == `EFA_FAS_POS) begin
            if (!fas_match(shift_n)) begin
              r_d.st = EFA_ST_SEARCH;
            end else if (r_q.xchk) begin
              r_d.st = EFA_ST_XNFAS;
            end else begin
              r_d.st = EFA_ST_SYNC;
            end
          end
        end
        EFA_ST_XNFAS: begin
          if (cnt_n == `EFA_NFAS_POS) begin
            r_d.st = rx_bit ? EFA_ST_XFAS : EFA_ST_SEARCH;
          end
        end
        EFA_ST_XFAS: begin
          if (cnt_n == `EFA_FAS_POS) begin
            r_d.st = fas_match(shift_n) ? EFA_ST_SYNC : EFA_ST_SEARCH;
          end
        end
        EFA_ST_HOLD: begin
          if (cnt_n == `EFA_FAS_POS) begin
            r_d.st = EFA_ST_SEARCH;
          end
        end
        EFA_ST_SYNC: begin
          // loss criteria live elsewhere; only restart leaves sync
          r_d.sts.frame_pulse = (cnt_n == `EFA_FAS_POS);
        end
        default: begin
          r_d.st = EFA_ST_SEARCH;
        end
      endcase
    end
    if (restart) begin
      r_d.st              = EFA_ST_SEARCH;
      r_d.sts.frame_pulse = 1'b0;
    end
    r_d.sts.in_sync   = (r_d.st == EFA_ST_SYNC);
    r_d.sts.searching = (r_d.st == EFA_ST_SEARCH);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r_q               <= '0;
      r_q.st            <= EFA_ST_SEARCH;
      r_q.alg           <= `EFA_ALG_RESET;
      r_q.xchk          <= `EFA_XCHK_RESET;
      r_q.sts.searching <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign status = r_q.sts;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_nfas_at_check;
    bit_stb && !restart && r_q.st == EFA_ST_NFAS && cnt_n == `EFA_NFAS_POS;
  endsequence

  sequence s_fas3_at_check;
    bit_stb && !restart && r_q.st == EFA_ST_FAS3 && cnt_n == `EFA_FAS_POS;
  endsequence

  sequence s_xnfas_at_check;
    bit_stb && !restart && r_q.st == EFA_ST_XNFAS && cnt_n == `EFA_NFAS_POS;
  endsequence

  sequence s_xfas_at_check;
    bit_stb && !restart && r_q.st == EFA_ST_XFAS && cnt_n == `EFA_FAS_POS;
  endsequence

  AST_ALG_FROM_CFG: assert property (
    r_q.st == EFA_ST_SEARCH |=> r_q.alg == $past(cfg.alignment_algorithm_select))
    else $error("algorithm select not taken during search");

  AST_SEARCH_FOUND: assert property (
    bit_stb && !restart && r_q.st == EFA_ST_SEARCH && shift_n == `EFA_FAS_PATTERN
    |=> r_q.st == EFA_ST_NFAS && r_q.cnt == `EFA_FAS_POS)
    else $error("found pattern did not start second step");

  AST_SEARCH_STAYS: assert property (
    bit_stb && !restart && r_q.st == EFA_ST_SEARCH && shift_n != `EFA_FAS_PATTERN
    |=> r_q.st == EFA_ST_SEARCH)
    else $error("search left without pattern");

  AST_NFAS_PASS: assert property (
    s_nfas_at_check and rx_bit |=> r_q.st == EFA_ST_FAS3)
    else $error("non-FAS bit one did not reach third step");

  AST_ALG1_FAIL: assert property (
    s_nfas_at_check and !rx_bit && !r_q.alg |=> r_q.st == EFA_ST_SEARCH ##1 r_q.sts.searching)
    else $error("first algorithm failure did not return to search");

  AST_FAS3_FAIL: assert property (
    s_fas3_at_check and shift_n != `EFA_FAS_PATTERN |=> r_q.st == EFA_ST_SEARCH)
    else $error("third step failure did not restart search");

  AST_SYNC_AT_ONCE: assert property (
    s_fas3_at_check and shift_n == `EFA_FAS_PATTERN && !r_q.xchk |=> r_q.sts.in_sync)
    else $error("sync not declared after three steps");

  AST_XCHK_DELAY: assert property (
    s_fas3_at_check and shift_n == `EFA_FAS_PATTERN && r_q.xchk
    |=> !r_q.sts.in_sync && r_q.st == EFA_ST_XNFAS)
    else $error("extra check skipped");

  AST_SYNC_ROSE: assert property (
    $rose(r_q.sts.in_sync) |-> $past(r_q.st) == EFA_ST_FAS3 || $past(r_q.st) == EFA_ST_XFAS)
    else $error("sync declared from a wrong step");

  AST_ALG2_FAIL: assert property (
    s_nfas_at_check and !rx_bit && r_q.alg |=> r_q.st == EFA_ST_HOLD)
    else $error("second algorithm failure did not hold off");

  AST_HOLD_END: assert property (
    bit_stb && !restart && r_q.st == EFA_ST_HOLD
    |=> (r_q.st == EFA_ST_SEARCH) == ($past(cnt_n) == `EFA_FAS_POS))
    else $error("hold-off did not end at assumed FAS");

  AST_SYNC_KEEPS: assert property (
    r_q.st == EFA_ST_SYNC && !restart |=> r_q.st == EFA_ST_SYNC && $stable(r_q.alg))
    else $error("sync disturbed");

  AST_XNFAS_STEP: assert property (
    s_xnfas_at_check |=> r_q.st == ($past(rx_bit) ? EFA_ST_XFAS : EFA_ST_SEARCH))
    else $error("extra non-FAS check went the wrong way");

  AST_XFAS_STEP: assert property (
    s_xfas_at_check |=> r_q.sts.in_sync == ($past(shift_n) == `EFA_FAS_PATTERN))
    else $error("extra FAS check went the wrong way");

  AST_PULSE_IN_SYNC: assert property (
    r_q.sts.frame_pulse |-> r_q.sts.in_sync)
    else $error("frame pulse outside sync");

  // bit strobes are never back to back, so a pulse cannot stretch
  AST_PULSE_SINGLE: assert property (
    r_q.sts.frame_pulse |=> !r_q.sts.frame_pulse)
    else $error("frame pulse longer than one cycle");

  AST_RESTART_SEARCH: assert property (
    restart |=> r_q.sts.searching && !r_q.sts.in_sync)
    else $error("restart did not return to search");

  AST_CFG_FROZEN: assert property (
    r_q.st != EFA_ST_SEARCH |=> $stable(r_q.alg) && $stable(r_q.xchk))
    else $error("config moved outside search");

endmodule

// ---- hdl/efa_regs.svh ----
`ifndef EFA_REGS_SVH
`define EFA_REGS_SVH

// bits 2..8 of timeslot 0 in a FAS frame, oldest bit in the msb
`define EFA_FAS_PATTERN 7'h1b
// bit position over a double frame of 512 bits
`define EFA_FAS_POS     9'h007
`define EFA_NFAS_POS    9'h101
`define EFA_ALG_RESET   1'b0
`define EFA_XCHK_RESET  1'b0

`endif

// ---- hdl/efa_pkg.sv ----
package efa_pkg;

  typedef enum logic [2:0] {
    EFA_ST_SEARCH,
    EFA_ST_NFAS,
    EFA_ST_FAS3,
    EFA_ST_XNFAS,
    EFA_ST_XFAS,
    EFA_ST_HOLD,
    EFA_ST_SYNC
  } efa_state_t;

  typedef struct packed {
    logic alignment_algorithm_select;
    logic extra_frame_check_en;
  } efa_cfg_t;

  typedef struct packed {
    logic in_sync;
    logic frame_pulse;
    logic searching;
  } efa_status_t;

  typedef struct packed {
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_s3;
    logic        dat_s1;
    logic        dat_s2;
    logic [6:0]  shift;
    logic [8:0]  cnt;
    efa_state_t  st;
    logic        alg;
    logic        xchk;
    efa_status_t sts;
  } efa_regs_t;

endpackage

// ---- tb/efa_e1_tx.sv ----
`timescale 1ns/1ps
`include "efa_regs.svh"
module efa_e1_tx (
  input  wire logic        sys_clk,
  input  wire logic        run,
  input  wire logic        bad_nfas,
  input  wire logic        bad_fas,
  output logic             line_clk,
  output logic             line_data,
  output logic [10:0]      gbit
);
  logic [2:0] ph = 3'h0;
  logic [7:0] i;
  logic       b;
  localparam logic [6:0] fas_bits = `EFA_FAS_PATTERN;
  initial begin
    line_clk = 1'b0;
    line_data = 1'b0;
    gbit = 11'h000;
  end
  assign i = gbit[7:0];
  // payload has a one in every even bit position, so no false 00 can fake a pattern
  always_comb begin
    if (i == 8'h00) b = 1'b1;
    else if (i < 8'h08 && !gbit[8]) b = fas_bits[3'(8'h07 - i)] ^ (bad_fas && i == 8'h02 && gbit[10:9] == 2'h1);
    else if (i < 8'h08) b = !(bad_nfas && i == 8'h01 && gbit[10:9] == 2'h0);
    else b = i[0] ? 1'($urandom) : 1'b1;
  end
  always @(posedge sys_clk) begin
    if (!run) begin
      ph <= 3'h0;
      gbit <= 11'h000;
      line_clk <= 1'b0;
      line_data <= ~line_data; // idle line shows no stale bit
    end else begin
      ph <= ph + 3'h1;
      line_clk <= ph >= 3'h3 && ph < 3'h7;
      if (ph == 3'h1) line_data <= b;
      if (ph == 3'h7) gbit <= gbit + 11'h001;
    end
  end
endmodule

// ---- tb/efa_fas_search_tb.sv ----
`timescale 1ns/1ps
module efa_fas_search_tb;
  import efa_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, run = 1'b0, bn = 1'b0, bf = 1'b0, restart = 1'b0;
  logic        line_clk, line_data;
  logic [10:0] gbit;
  logic [3:0]  r;
  efa_cfg_t    cfg = '0;
  efa_status_t status;
  int          fail_count = 0, compares = 0, pulses = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (status.frame_pulse === 1'b1) pulses++;
  efa_fas_search efa_fas_search_inst (.sys_clk(sys_clk), .rstn(rstn), .line_clk(line_clk),
    .line_data(line_data), .restart(restart), .cfg(cfg), .status(status));
  efa_e1_tx efa_e1_tx_inst (.sys_clk(sys_clk), .run(run), .bad_nfas(bn), .bad_fas(bf),
    .line_clk(line_clk), .line_data(line_data), .gbit(gbit));
  task automatic check(input logic s, input logic e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // targets sit a few bits past each event to cover the synchroniser delay
  task automatic upto(input int g);
    int n;
    n = 0;
    while (gbit < g && n < 20000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      final_report();
    end else begin
      @(posedge sys_clk);
      #2;
    end
  endtask
  task automatic run_case(input logic alg, input logic xc, input logic cn, input logic cf);
    @(posedge sys_clk);
    #2;
    rstn = 1'b0;
    run = 1'b0;
    cfg = '{alg, xc};
    bn = cn;
    bf = cf;
    repeat (12) @(posedge sys_clk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    check(status.searching, 1'b1);
    check(status.in_sync, 1'b0);
    run = 1'b1;
    upto(12);
    check(status.searching, 1'b0);
    upto(262);
    check(status.searching, cn & ~alg);
    upto(524);
    // a corrupted third-frame pattern cannot be re-found by a fresh search
    if (cn) check(status.searching, alg | cf);
    else begin
      check(status.in_sync, ~cf & ~xc);
      check(status.searching, cf);
    end
    if (!cn && !cf) begin
      upto(1036);
      check(status.in_sync, 1'b1);
      pulses = 0;
      upto(1548);
      check(pulses == 1, 1'b1);
      cfg.alignment_algorithm_select = ~alg;
      repeat (40) @(posedge sys_clk);
      #2;
      check(status.in_sync, 1'b1);
      restart = 1'b1;
      @(posedge sys_clk);
      #2 restart = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      check(status.searching, 1'b1);
      check(status.in_sync, 1'b0);
    end
    $display("case done alg=%h xchk=%h nfas_bad=%h fas_bad=%h", alg, xc, cn, cf);
  endtask
  initial begin
    r = 4'($urandom(86));
    run_case(1'b0, 1'b0, 1'b0, 1'b0);
    run_case(1'b1, 1'b1, 1'b0, 1'b0);
    run_case(1'b0, 1'b0, 1'b1, 1'b0);
    run_case(1'b1, 1'b0, 1'b1, 1'b0);
    run_case(1'b0, 1'b1, 1'b0, 1'b1);
    repeat (3) begin
      r = 4'($urandom);
      run_case(r[0], r[1], r[2], r[3]);
    end
    final_report();
  end
endmodule
